// file: verilog/ebsc_pkg.sv
// Package for the external bus signal control block.
// Holds pin-group carriers, bus states, memory map limits and counts.
package ebsc_pkg;

  // Address map: partitions steered by the latched access select, then the upper space that is always external
  localparam logic [15:0] EBSC_SP_LO = 16'h0000;
  localparam logic [15:0] EBSC_SP_HI = 16'h00ff;
  localparam logic [15:0] EBSC_PM_LO = 16'h2000;
  localparam logic [15:0] EBSC_PM_HI = 16'h7fff;
  localparam logic [15:0] EBSC_EXT_LO = 16'h8000;

  // Reset values of pins and registers
  localparam logic [7:0] EBSC_PORT_RST = 8'hff;
  localparam logic EBSC_STROBE_ADV_RST = 1'b1;
  localparam logic EBSC_CLOCK_OUTPUT_RST = 1'b0;

  // Cycle counts per bus phase (clock cycles)
  localparam logic [1:0] EBSC_ADDR_CYC = 2'h2;
  localparam logic [1:0] EBSC_DATA_CYC = 2'h2;
  localparam logic [1:0] EBSC_CYC_ONE = 2'h1;

  // Bus controller states
  typedef enum logic [1:0] {
    EBSC_IDLE,
    EBSC_ADDR,
    EBSC_DATA,
    EBSC_DONE
  } ebsc_state_t;

  // Access request from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ebsc_req_t;

  // Two-signal view of the shared address/data pins
  typedef struct packed {
    logic [15:0] dout;
    logic [15:0] oe;
  } ebsc_ad_t;

endpackage

// file: verilog/ebsc_clkdiv.sv
// Clock output divider for the external bus signal control block.
// Assumes ref_clk is the oscillator input; output toggles every rising edge.
`timescale 1ns/100ps
module ebsc_clkdiv (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Divided clock
  output logic clock_output
);
  import ebsc_pkg::*;

  logic next_clock_output;

  // Toggle each rising edge: half rate, equal high and low
  always_comb begin
    next_clock_output = ~clock_output;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clock_output <= EBSC_CLOCK_OUTPUT_RST;
    end else begin
      clock_output <= next_clock_output;
    end
  end

  // First edge after release still shows the reset level on both sides
  a_clk_toggle: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> clock_output != $past(clock_output))
    else $error("clock output did not toggle");

  a_clk_duty: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(clock_output) |=> $fell(clock_output))
    else $error("clock output high time not one cycle");

endmodule

// file: verilog/ebsc_top.sv
// External bus signal control: multiplexed address/data bus sequencing,
// shared strobe pin, general port fallback, clock output, access select.
// Assumes the core presents one request at a time and waits for done.
// Operation
// - Address phase drives all sixteen address bits on shared lines.
// - Data phase moves eight or sixteen bits per bus and access width.
// - Address valid asserts only for external accesses.
// - Address valid low whole cycle, high right when cycle completes.
// - Latch strobe only in external cycles, marking start and address.
// - Valid and latch strobes share one pin, else general port bit.
// - Low byte doubles as port three, high byte as port four.
// - Clock output is exactly half the oscillator frequency.
// - Clock output has equal high and low times.
// - Special and program partitions go internal if select high.
// - Other locations route regardless of the select level.
// - Select captured only at reset release; later changes ignored.
`timescale 1ns/100ps
module ebsc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Core request and answer
  input wire ebsc_pkg::ebsc_req_t req,
  output logic req_ready,
  output logic done,
  output logic done_internal,
  output logic [15:0] rdata,
  // Configuration
  input wire logic bus_wide,
  input wire logic strobe_is_ale,
  input wire logic port_five_sel,
  input wire logic [7:0] port_three_bits,
  input wire logic [7:0] port_four_bits,
  input wire logic port_five_bit_zero,
  // Access select strap
  input wire logic ext_access_select_n,
  // Shared address/data pins
  input wire logic [15:0] addr_data_in,
  output logic [15:0] addr_data_lines,
  output logic [15:0] addr_data_oe,
  // Strobe pin and clock pin
  output logic strobe_pin,
  output logic clock_output
);
  import ebsc_pkg::*;

  // Decide whether an address leaves the chip
  function automatic logic is_external(input logic [15:0] a,
                                       input logic sel_high);
    logic part;
    part = (a >= EBSC_SP_LO && a <= EBSC_SP_HI) ||
           (a >= EBSC_PM_LO && a <= EBSC_PM_HI);
    if (part) begin
      is_external = !sel_high;
    end else begin
      is_external = (a >= EBSC_EXT_LO);
    end
  endfunction

  ebsc_state_t state;
  ebsc_state_t next_state;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  ebsc_req_t cur;
  ebsc_req_t next_cur;
  logic ea_high;
  logic next_ea_high;
  logic ea_taken;
  logic next_ea_taken;
  logic addr_valid_n;
  logic next_addr_valid_n;
  logic ale;
  logic next_ale;
  ebsc_ad_t ad;
  ebsc_ad_t next_ad;
  logic [15:0] next_rdata;
  logic next_done;
  logic next_done_internal;
  logic strobe;
  logic next_strobe;

  // Access select captured once, on the first edge after reset release
  always_comb begin
    next_ea_taken = 1'b1;
    next_ea_high = ea_high;
    if (!ea_taken) begin
      next_ea_high = ext_access_select_n;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ea_taken <= 1'b0;
      ea_high <= 1'b1;
    end else begin
      ea_taken <= next_ea_taken;
      ea_high <= next_ea_high;
    end
  end

  assign req_ready = (state == EBSC_IDLE) && ea_taken;

  // Bus sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cur = cur;
    next_addr_valid_n = 1'b1;
    next_ale = 1'b0;
    next_ad.dout = {port_four_bits, port_three_bits};
    next_ad.oe = 16'hffff;
    next_rdata = rdata;
    next_done = 1'b0;
    next_done_internal = 1'b0;
    unique case (state)
      EBSC_IDLE: begin
        if (req.valid && req_ready) begin
          if (is_external(req.addr, ea_high)) begin
            next_cur = req;
            next_state = EBSC_ADDR;
            next_cnt = EBSC_ADDR_CYC;
            next_addr_valid_n = 1'b0;
            next_ale = 1'b1;
            next_ad.dout = req.addr;
            next_ad.oe = 16'hffff;
          end else begin
            next_done_internal = 1'b1;
          end
        end
      end
      EBSC_ADDR: begin
        next_addr_valid_n = 1'b0;
        next_ad.dout = cur.addr;
        next_ale = (cnt != EBSC_CYC_ONE);
        next_cnt = cnt - EBSC_CYC_ONE;
        if (cnt == EBSC_CYC_ONE) begin
          next_state = EBSC_DATA;
          next_cnt = EBSC_DATA_CYC;
          next_ad.dout = cur.wdata;
          next_ad.oe = cur.write ? 16'hffff : 16'h0000;
          if (!(bus_wide && cur.wide)) begin
            next_ad.oe[15:8] = 8'h00;
          end
        end
      end
      EBSC_DATA: begin
        next_addr_valid_n = 1'b0;
        next_ad = ad;
        next_cnt = cnt - EBSC_CYC_ONE;
        if (cnt == EBSC_CYC_ONE) begin
          next_state = EBSC_DONE;
          next_addr_valid_n = 1'b1;
          next_ad.dout = {port_four_bits, port_three_bits};
          next_ad.oe = 16'hffff;
          next_done = 1'b1;
          if (!cur.write) begin
            next_rdata = (bus_wide && cur.wide) ? addr_data_in :
                         {8'h00, addr_data_in[7:0]};
          end
        end
      end
      EBSC_DONE: begin
        next_state = EBSC_IDLE;
      end
      default: begin
        next_state = EBSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= EBSC_IDLE;
      cnt <= 2'h0;
      cur <= '0;
      addr_valid_n <= EBSC_STROBE_ADV_RST;
      ale <= 1'b0;
      ad.dout <= {EBSC_PORT_RST, EBSC_PORT_RST};
      ad.oe <= 16'h0000;
      rdata <= 16'h0000;
      done <= 1'b0;
      done_internal <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur <= next_cur;
      addr_valid_n <= next_addr_valid_n;
      ale <= next_ale;
      ad <= next_ad;
      rdata <= next_rdata;
      done <= next_done;
      done_internal <= next_done_internal;
    end
  end

  // Shared strobe pin: valid, latch enable or port bit
  always_comb begin
    if (port_five_sel) begin
      next_strobe = port_five_bit_zero;
    end else if (strobe_is_ale) begin
      next_strobe = next_ale;
    end else begin
      next_strobe = next_addr_valid_n;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strobe <= EBSC_STROBE_ADV_RST;
    end else begin
      strobe <= next_strobe;
    end
  end

  assign strobe_pin = strobe;
  assign addr_data_lines = ad.dout;
  assign addr_data_oe = ad.oe;

  ebsc_clkdiv u_clkdiv (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clock_output(clock_output)
  );

  // Cycle shapes
  sequence s_start;
    $fell(addr_valid_n) && ale;
  endsequence
  sequence s_addr_hold;
    (!addr_valid_n && addr_data_lines == cur.addr)[*2];
  endsequence

  a_addr_phase: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_start |-> s_addr_hold)
    else $error("address not held during address phase");

  a_narrow_oe: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == EBSC_DATA && !(bus_wide && cur.wide)) |->
      addr_data_oe[15:8] == 8'h00)
    else $error("high byte driven in narrow data phase");

  a_int_no_adv: assert property (@(posedge ref_clk) disable iff (!nrst)
    done_internal |-> addr_valid_n && !ale)
    else $error("strobe on internal access");

  a_adv_span: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_start |-> !addr_valid_n[*4] ##1 addr_valid_n && done)
    else $error("address valid span wrong");

  a_ale_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(ale) |-> state == EBSC_ADDR && !addr_valid_n)
    else $error("latch strobe outside cycle start");

  a_strobe_mux: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!port_five_sel && !strobe_is_ale && !$past(port_five_sel) &&
     !$past(strobe_is_ale)) |-> strobe_pin == addr_valid_n)
    else $error("strobe pin not following address valid");

  a_ea_fixed: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(ea_taken) |-> $stable(ea_high))
    else $error("access select changed after reset");

  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == EBSC_IDLE) |-> addr_valid_n && !ale)
    else $error("strobe active while idle");

  a_ext_route: assert property (@(posedge ref_clk) disable iff (!nrst)
    (req.valid && req_ready && req.addr >= EBSC_PM_LO &&
     req.addr <= EBSC_PM_HI && ea_high) |=> done_internal)
    else $error("program partition not internal with select high");

  a_high_route: assert property (@(posedge ref_clk) disable iff (!nrst)
    (req.valid && req_ready && req.addr >= EBSC_EXT_LO) |=>
      state == EBSC_ADDR)
    else $error("upper space not external");

endmodule

// file: test/ebsc_mem_model.sv
// Memory partner on the far side of the shared address/data pins.
// Assumes the strobe pin shows either latch enable or address valid.
`timescale 1ns/100ps
module ebsc_mem_model (
  // Clock
  input wire logic ref_clk,
  // Pins seen from the device
  input wire logic strobe_pin,
  input wire logic is_ale,
  input wire logic [15:0] ad_out,
  input wire logic [15:0] ad_oe,
  // Pins driven back
  output logic [15:0] ad_in
);
  logic [15:0] addr = 16'h0;
  logic [2:0] cnt = 3'h0;
  logic prev = 1'b1;
  initial ad_in = 16'h0;
  // Latch the address at the strobe, then count the cycle out
  always @(posedge ref_clk) begin
    prev <= strobe_pin;
    if (is_ale ? strobe_pin : (prev && !strobe_pin)) begin
      addr <= ad_out;
      cnt <= 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  // Read data only while the device lets go, else a toggling pattern
  always @(negedge ref_clk) begin
    if (cnt != 3'h0 && ad_oe == 16'h0) begin
      ad_in <= addr ^ 16'h5a5a;
    end else begin
      ad_in <= ~ad_in;
    end
  end
endmodule

// file: test/tb_top.sv
// Self-checking bench for the external bus signal control block.
// Assumes the partner answers a read with the address xor 5a5a.
`timescale 1ns/100ps
module tb_top;
  import ebsc_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  ebsc_req_t req = '0;
  logic req_ready, done, done_internal, strobe_pin, clock_output;
  logic [15:0] rdata, ad_in, ad_out, ad_oe;
  logic bus_wide = 1'b1, is_ale = 1'b0, p5_sel = 1'b0, p5 = 1'b1;
  logic [7:0] p3 = 8'h0, p4 = 8'h0;
  logic ea_n = 1'b1, ea_lat = 1'b1, last_clk = 1'b0, nrst_d = 1'b0;
  int n_errors = 0, n_compared = 0, cycles = 0, seed = 32'h8257;

  // Clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  ebsc_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .req(req),
    .req_ready(req_ready), .done(done), .done_internal(done_internal),
    .rdata(rdata), .bus_wide(bus_wide), .strobe_is_ale(is_ale),
    .port_five_sel(p5_sel), .port_three_bits(p3), .port_four_bits(p4),
    .port_five_bit_zero(p5), .ext_access_select_n(ea_n),
    .addr_data_in(ad_in), .addr_data_lines(ad_out),
    .addr_data_oe(ad_oe), .strobe_pin(strobe_pin),
    .clock_output(clock_output));

  ebsc_mem_model u_mem (.ref_clk(ref_clk), .strobe_pin(strobe_pin),
    .is_ale(is_ale), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Reset with a strap level, then flip the strap after capture
  task automatic do_reset(input logic ea);
    @(posedge ref_clk);
    nrst <= 1'b0;
    ea_n <= ea;
    repeat (3) @(posedge ref_clk);
    chk(ad_oe, 16'h0);
    chk(16'(strobe_pin), 16'h1);
    nrst <= 1'b1;
    ea_lat = ea;
    @(posedge ref_clk);
    ea_n <= ~ea;
  endtask

  // One access, checked cycle by cycle against the model
  task automatic access(input logic wr, input logic wd,
    input logic [15:0] a, input logic [15:0] wdat);
    logic ext, st;
    logic [15:0] m, f;
    ext = a >= EBSC_EXT_LO || (!ea_lat && (a <= EBSC_SP_HI ||
      (a >= EBSC_PM_LO && a <= EBSC_PM_HI)));
    m = (wd && bus_wide) ? 16'hffff : 16'h00ff;
    f = a ^ 16'h5a5a;
    req <= '{1'b1, wr, wd, a, wdat};
    @(negedge ref_clk);
    while (!req_ready) @(negedge ref_clk);
    @(posedge ref_clk);
    req.valid <= 1'b0;
    for (int k = 1; k <= 5; k++) begin
      @(negedge ref_clk);
      st = is_ale ? (ext && k < 3) : !(ext && k < 5);
      if (p5_sel) st = p5;
      chk({12'h0, req_ready, strobe_pin, done, done_internal},
        {12'h0, !ext, st, ext && k == 5, !ext && k == 1});
      if (ext && k < 3) begin
        chk(ad_out, a);
        chk(ad_oe, 16'hffff);
      end else if (ext && k < 5) begin
        chk(ad_oe, wr ? m : 16'h0);
        if (wr) chk(ad_out & m, wdat & m);
      end else begin
        chk(ad_out, {p4, p3});
      end
    end
    if (ext && !wr) chk(rdata, f & m);
    @(posedge ref_clk);
  endtask

  // Divided clock toggles on every reference cycle
  always @(negedge ref_clk) begin
    if (nrst && nrst_d) chk(16'(clock_output), 16'(!last_clk));
    last_clk <= clock_output;
    nrst_d <= nrst;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      finish_test();
    end
  end

  // Every strobe mode and width, then the strap captured low
  initial begin
    do_reset(1'b1);
    for (int i = 0; i < 6; i++) begin
      bus_wide <= i[0];
      is_ale <= i[1];
      p5_sel <= (i == 5);
      p3 <= 8'($random(seed));
      p4 <= 8'($random(seed));
      p5 <= 1'($random(seed));
      // Let the strobe pin show its idle level in the new mode
      @(posedge ref_clk);
      if (i != 5) access(1'b0, 1'($random(seed)),
        16'($random(seed)) | 16'h8000, 16'h0);
      access(1'b1, 1'($random(seed)), 16'($random(seed)) | 16'h8000,
        16'($random(seed)));
      access(1'b0, 1'b1, EBSC_PM_LO, 16'h0);
      access(1'b0, 1'b0, 16'h1234, 16'h0);
      $display("mode %0d done", i);
    end
    p5_sel <= 1'b0;
    do_reset(1'b0);
    access(1'b0, 1'b1, EBSC_SP_HI, 16'h0);
    access(1'b1, 1'b1, EBSC_PM_HI, 16'h0a5c);
    access(1'b0, 1'b1, 16'h1234, 16'h0);
    $display("strap low test done");
    finish_test();
  end
endmodule
